// file: rtl/micsl_regs.svh
`ifndef MICSL_REGS_SVH
`define MICSL_REGS_SVH
// Frame layout in bit-clock cycles
`define MICSL_FRAME_SCK 64
`define MICSL_HALF_SCK 32
`define MICSL_WORD_BITS 24
`define MICSL_MSB_DELAY 1
// System clock rate
`define MICSL_CLK_HZ 125000000
// Start-up bound, ms
`define MICSL_STARTUP_MS 20
// Standby threshold on bit clock, Hz
`define MICSL_STBY_SCK_HZ 200000
// Frame-rate thresholds, Hz (all scaled by 4)
`define MICSL_SLEEP_FS_X4 12500
`define MICSL_LP_MIN_FS_X4 25000
`define MICSL_LP_MAX_FS_X4 75000
// Sleep entry bound, ms
`define MICSL_SLEEP_MS 1
// Wake delay in bit-clock cycles
`define MICSL_WAKE_SCK 32768
`endif

// file: rtl/micsl_pkg.sv
package micsl_pkg;
  typedef enum logic [1:0] {MICSL_SLEEP, MICSL_STANDBY, MICSL_LOWPWR, MICSL_HIPERF} micsl_pwr_t;
  typedef struct packed {
    logic data;
    logic oe;
  } micsl_sd_t;
endpackage : micsl_pkg

// file: rtl/micsl_hpf.sv
`timescale 1ns/1ps
`default_nettype none
// First-order DC blocker, y = x - x1 + a*y1, a = 1 - 2^-SHIFT
module micsl_hpf #(
  parameter int W = 24,
  parameter int SHIFT = 10
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic stb_in,
  input wire logic signed [W-1:0] x_in,
  output logic signed [W-1:0] y_out
);
  logic signed [W+SHIFT+1:0] acc;
  logic signed [W-1:0] x1;
  logic signed [W+SHIFT+1:0] next_acc;
  always_comb begin
    // Widen before subtracting so a full-scale step cannot wrap
    next_acc = acc - (acc >>> SHIFT) + (((W+SHIFT+2)'(x_in) - (W+SHIFT+2)'(x1)) <<< SHIFT);
  end
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      acc <= '0;
      x1 <= '0;
    end else if (stb_in) begin
      acc <= next_acc;
      x1 <= x_in;
    end
  end
  assign y_out = W'(acc >>> SHIFT);
endmodule : micsl_hpf
`default_nettype wire

// file: rtl/micsl_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "micsl_regs.svh"
module micsl_top #(
  parameter int WAKE_SCK = `MICSL_WAKE_SCK,
  parameter int SLEEP_CYC = (`MICSL_CLK_HZ / 1000) * `MICSL_SLEEP_MS,
  parameter int STARTUP_CYC = (`MICSL_CLK_HZ / 1000) * `MICSL_STARTUP_MS
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic sck_in,
  input wire logic ws_in,
  input wire logic channel_slot_select_in,
  input wire logic signed [23:0] pcm_in,
  input wire logic pcm_valid_in,
  output logic sd_out,
  output logic sd_oe_out,
  output micsl_pkg::micsl_pwr_t pwr_state_out,
  output logic reduced_power_state_out,
  output logic sample_strobe_out
);
  import micsl_pkg::*;

  // Bit-clock and frame period limits in system cycles; longer periods mean slower clocks
  localparam int STBY_PER = `MICSL_CLK_HZ / `MICSL_STBY_SCK_HZ;
  localparam int SLEEP_FR = (`MICSL_CLK_HZ * 4) / `MICSL_SLEEP_FS_X4;
  localparam int LP_FR_MAX = (`MICSL_CLK_HZ * 4) / `MICSL_LP_MIN_FS_X4;
  localparam int LP_FR_MIN = (`MICSL_CLK_HZ * 4) / `MICSL_LP_MAX_FS_X4;
  localparam int HALF = `MICSL_HALF_SCK;
  localparam int WB = `MICSL_WORD_BITS;
  localparam int DLY = `MICSL_MSB_DELAY;

  // ---------------- Link domain (bit clock) ----------------
  // WS sampled on rising SCK; data launched on falling SCK
  logic ws_d;
  logic [5:0] bit_cnt;
  logic [15:0] wake_cnt;
  logic awake_l;
  logic [23:0] shreg;
  micsl_sd_t sd_l;
  logic sel_m;
  logic sel_s;
  logic rearm_m;
  logic rearm_s;
  logic [23:0] word_hold;

  // Rearm request (level) from system side, resynchronised into link domain
  logic rearm_req;
  always_ff @(posedge sck_in) begin
    rearm_m <= rearm_req;
    rearm_s <= rearm_m;
  end

  // Slot-select pin is static but still comes from outside; two flops first
  always_ff @(posedge sck_in) begin
    sel_m <= channel_slot_select_in;
    sel_s <= sel_m;
  end

  always_ff @(posedge sck_in) begin
    ws_d <= ws_in;
    if (ws_d != ws_in) begin
      bit_cnt <= 6'h00;
    end else begin
      bit_cnt <= bit_cnt + 6'h01;
    end
  end

  // Wake counter restarts while system side holds the block asleep or in standby
  always_ff @(posedge sck_in) begin
    if (rearm_s) begin
      wake_cnt <= 16'h0000;
      awake_l <= 1'b0;
    end else if (!awake_l) begin
      wake_cnt <= wake_cnt + 16'h0001;
      if (wake_cnt == 16'(WAKE_SCK - 1)) begin
        awake_l <= 1'b1;
      end
    end
  end

  // Word is loaded at its slot edge; word_hold is quasi-static, captured
  // a full half-frame before use, so a plain transfer is safe here
  wire slot_edge = sel_s ? (!ws_d && ws_in) : (ws_d && !ws_in);
  // Shift after each launched bit so the next falling edge sees the next bit
  always_ff @(posedge sck_in) begin
    if (slot_edge) begin
      shreg <= word_hold;
    end else if (bit_cnt >= 6'(DLY - 1) && bit_cnt < 6'(DLY - 1 + WB)) begin
      shreg <= {shreg[22:0], 1'b0};
    end
  end

  wire in_slot = (ws_d == sel_s);
  // Launch on falling SCK: cycle 0 of the half is empty, bits 1..24 carry data
  always_ff @(negedge sck_in) begin
    sd_l.oe <= awake_l && in_slot &&
               bit_cnt >= 6'(DLY - 1) && bit_cnt < 6'(DLY - 1 + WB);
    sd_l.data <= shreg[23];
  end

  // ---------------- System domain ----------------
  logic sck_m, sck_s, sck_p;
  logic tgl_m, tgl_s, tgl_p;
  logic [15:0] sck_per_cnt;
  logic [19:0] fr_cnt;
  logic [19:0] fr_period;
  logic [23:0] idle_cnt;
  logic [21:0] start_cnt;
  micsl_pwr_t pwr;
  logic sd_m, sd_s, oe_m, oe_s;
  logic awake_m;
  logic awake_s;
  logic first_drive_seen;

  always_ff @(posedge clk_sys_in) begin
    sck_m <= sck_in;
    sck_s <= sck_m;
    sck_p <= sck_s;
    tgl_m <= ws_d;
    tgl_s <= tgl_m;
    tgl_p <= tgl_s;
    awake_m <= awake_l;
    awake_s <= awake_m;
  end
  wire sck_rise = sck_s && !sck_p;
  // Registered WS level rather than a toggle: the link side has no reset,
  // and a level settles after the first bit clock where a toggle stays unknown
  wire frame_evt = tgl_p && !tgl_s;

  // Bit-clock period watch: too long between edges means standby
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in || sck_rise) begin
      sck_per_cnt <= 16'h0000;
    end else if (sck_per_cnt != 16'hffff) begin
      sck_per_cnt <= sck_per_cnt + 16'h0001;
    end
  end
  wire sck_slow = sck_per_cnt > 16'(STBY_PER);

  // Frame period measurement for the rate-based modes
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      fr_cnt <= 20'h00000;
      fr_period <= 20'hfffff;
    end else if (frame_evt) begin
      fr_period <= fr_cnt;
      fr_cnt <= 20'h00000;
    end else if (fr_cnt != 20'hfffff) begin
      fr_cnt <= fr_cnt + 20'h00001;
    end
  end
  // No frame for longer than the sleep period counts as slow too
  wire fr_slow = (fr_period > 20'(SLEEP_FR)) || (fr_cnt > 20'(SLEEP_FR));

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in || !fr_slow) begin
      idle_cnt <= 24'h000000;
    end else if (idle_cnt != 24'hffffff) begin
      idle_cnt <= idle_cnt + 24'h000001;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      pwr <= MICSL_SLEEP;
    end else if (sck_slow && fr_slow && idle_cnt >= 24'(SLEEP_CYC - 1)) begin
      pwr <= MICSL_SLEEP;
    end else if (sck_slow) begin
      pwr <= MICSL_STANDBY;
    end else if (!fr_slow && fr_period >= 20'(LP_FR_MIN) && fr_period <= 20'(LP_FR_MAX)) begin
      pwr <= MICSL_LOWPWR;
    end else begin
      // Running bit clock with no frame measured yet counts as normal mode
      pwr <= MICSL_HIPERF;
    end
  end

  // Start-up bound: wake delay re-armed while not in a normal mode
  // Held until the link side reports its wake counter cleared; a stopped bit
  // clock freezes the link flops, so their stale drive must stay masked
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in || sck_slow) begin
      rearm_req <= 1'b1;
    end else if (!awake_s) begin
      rearm_req <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in || rearm_req) begin
      start_cnt <= 22'h000000;
    end else if (start_cnt != 22'h3fffff) begin
      start_cnt <= start_cnt + 22'h000001;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in || rearm_req) begin
      first_drive_seen <= 1'b0;
    end else if (sd_oe_out) begin
      first_drive_seen <= 1'b1;
    end
  end

  // Sample path: high-pass then capture at frame start
  logic signed [23:0] hp_y;
  micsl_hpf #(.W(24), .SHIFT(10)) u_hpf (
    .clk_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .stb_in(pcm_valid_in),
    .x_in(pcm_in),
    .y_out(hp_y)
  );

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      word_hold <= 24'h000000;
      sample_strobe_out <= 1'b0;
    end else begin
      sample_strobe_out <= frame_evt;
      if (frame_evt) begin
        word_hold <= hp_y;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      pwr_state_out <= MICSL_SLEEP;
      reduced_power_state_out <= 1'b0;
    end else begin
      pwr_state_out <= pwr;
      reduced_power_state_out <= (pwr == MICSL_LOWPWR);
    end
  end

  // Pad: link-domain drive brought into system clock for the port flops
  always_ff @(posedge clk_sys_in) begin
    sd_m <= sd_l.data;
    sd_s <= sd_m;
    oe_m <= sd_l.oe;
    oe_s <= oe_m;
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      sd_out <= 1'b0;
      sd_oe_out <= 1'b0;
    end else begin
      sd_out <= sd_s;
      sd_oe_out <= oe_s && !rearm_req;
    end
  end

  property p_sleep_releases;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (pwr == MICSL_SLEEP) |=> ##1 !sd_oe_out;
  endproperty
  a_sleep_releases: assert property (p_sleep_releases)
    else $error("data driven in sleep");

  property p_lp_flag;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    reduced_power_state_out == ($past(pwr) == MICSL_LOWPWR);
  endproperty
  a_lp_flag: assert property (p_lp_flag)
    else $error("lp flag wrong");

  // Bounds the wait from clock restart to the first driven bit
  property p_startup;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    !first_drive_seen |-> start_cnt < 22'(STARTUP_CYC);
  endproperty
  a_startup: assert property (p_startup)
    else $error("start-up too long");

  property p_strobe;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    frame_evt |=> sample_strobe_out && word_hold == $past(hp_y);
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("sample miss");

  property p_standby_no_drive;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (pwr == MICSL_STANDBY) |=> ##1 !sd_oe_out;
  endproperty
  a_standby_no_drive: assert property (p_standby_no_drive)
    else $error("drive in standby");

  property p_rearm;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (pwr == MICSL_STANDBY) |-> rearm_req;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("no rearm");

  property p_slow_standby;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (sck_slow && !(fr_slow && idle_cnt >= 24'(SLEEP_CYC - 1))) |=> pwr == MICSL_STANDBY;
  endproperty
  a_slow_standby: assert property (p_slow_standby)
    else $error("no standby");

  property p_oe_quiet;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    $rose(sd_oe_out) |-> !$past(rearm_req);
  endproperty
  a_oe_quiet: assert property (p_oe_quiet)
    else $error("oe while rearmed");

  property p_rearm_releases;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    rearm_req |=> !sd_oe_out;
  endproperty
  a_rearm_releases: assert property (p_rearm_releases)
    else $error("drive while rearmed");

  property p_fast_hiperf;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (!sck_slow && !fr_slow && fr_period < 20'(LP_FR_MIN)) |=> pwr == MICSL_HIPERF;
  endproperty
  a_fast_hiperf: assert property (p_fast_hiperf)
    else $error("not in normal mode");

  property p_lp_enter;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (!sck_slow && !fr_slow && fr_period >= 20'(LP_FR_MIN) && fr_period <= 20'(LP_FR_MAX))
      |=> pwr == MICSL_LOWPWR;
  endproperty
  a_lp_enter: assert property (p_lp_enter)
    else $error("low-power band missed");

  property p_sleep_needs_slow;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (pwr != MICSL_SLEEP) ##1 (pwr == MICSL_SLEEP) |-> $past(sck_slow) && $past(fr_slow);
  endproperty
  a_sleep_needs_slow: assert property (p_sleep_needs_slow)
    else $error("sleep entered at speed");
endmodule : micsl_top
`default_nettype wire

// file: tb/micsl_host.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural I2S master; reads the shared data line through a pull-down
module micsl_host (
  input wire logic run_in,
  input wire logic sel_in,
  input wire logic [15:0] half_ns_in,
  input wire logic sd_in,
  input wire logic sd_oe_in,
  output logic sck_out,
  output logic ws_out,
  output logic woke_out,
  output logic [23:0] word_out,
  output int frames_out,
  output int bad_out
);
  logic [5:0] pos;
  logic [23:0] shreg;
  logic in_slot;
  initial begin
    {sck_out, ws_out, woke_out} = 3'h0;
    word_out = 24'h0;
    shreg = 24'h0;
    frames_out = 0;
    bad_out = 0;
    pos = 6'h3f;
    forever begin
      if (!run_in) begin
        // Both lines parked low so no current flows into the select pull-down
        {sck_out, ws_out, woke_out} = 3'h0;
        pos = 6'h3f;
        #8;
      end else begin
        #(half_ns_in);
        sck_out = 1'b1;
        in_slot = (pos[5] == sel_in) && (pos[4:0] >= 5'h01) && (pos[4:0] <= 5'h18);
        if (sd_oe_in === 1'b1) woke_out = 1'b1;
        // Once awake, drive must match the slot exactly, bit by bit
        if (woke_out && sd_oe_in !== in_slot) bad_out++;
        if (in_slot) shreg = {shreg[22:0], sd_oe_in ? sd_in : 1'b0};
        if (in_slot && pos[4:0] == 5'h18) word_out = shreg;
        #(half_ns_in);
        sck_out = 1'b0;
        pos = pos + 6'h01;
        ws_out = pos[5];
        if (pos == 6'h00) frames_out++;
      end
    end
  end
endmodule : micsl_host
`default_nettype wire

// file: tb/micsl_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module micsl_top_test;
  import micsl_pkg::*;
  typedef struct packed {logic sel; logic [23:0] val;} micsl_row_t;
  localparam int WAKE = 64;
  logic clk_sys_in = 1'b0;
  logic rst_b = 1'b0;
  logic run = 1'b0;
  logic sel = 1'b0;
  logic pcm_valid = 1'b0;
  logic signed [23:0] pcm = 24'sh0;
  logic [15:0] half_ns = 16'h0020;
  logic sck, ws, sd, sd_oe, rps, strobe, woke;
  logic [23:0] word;
  micsl_pwr_t pwr;
  int frames, bad, n;
  int n_strobe = 0;
  int n_errors = 0;
  int n_compared = 0;
  micsl_row_t rows [4] = '{'{1'b0, 24'h7fffff}, '{1'b1, 24'h800000},
                           '{1'b0, 24'h000001}, '{1'b1, 24'ha5c3e1}};

  micsl_top #(.WAKE_SCK(WAKE), .SLEEP_CYC(2000)) dut (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b), .sck_in(sck), .ws_in(ws),
    .channel_slot_select_in(sel), .pcm_in(pcm), .pcm_valid_in(pcm_valid),
    .sd_out(sd), .sd_oe_out(sd_oe), .pwr_state_out(pwr),
    .reduced_power_state_out(rps), .sample_strobe_out(strobe));
  micsl_host host (
    .run_in(run), .sel_in(sel), .half_ns_in(half_ns), .sd_in(sd), .sd_oe_in(sd_oe),
    .sck_out(sck), .ws_out(ws), .woke_out(woke), .word_out(word),
    .frames_out(frames), .bad_out(bad));

  initial forever #4 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (strobe === 1'b1) n_strobe++;

  task automatic summarize;
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic fail(input string msg);
    $display("Error at %0t: %s", $time, msg);
    n_errors++;
  endtask : fail
  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) fail($sformatf("word %h, expected %h", got, exp));
  endtask : chk_word
  task automatic chk_pwr(input micsl_pwr_t got, input micsl_pwr_t exp);
    n_compared++;
    if (got !== exp) fail($sformatf("power state %0d, expected %0d", got, exp));
  endtask : chk_pwr
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) fail($sformatf("flag %b, expected %b", got, exp));
  endtask : chk_bit
  task automatic chk_int(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) fail($sformatf("count %0d outside %0d..%0d", got, lo, hi));
  endtask : chk_int
  task automatic wait_frames(input int k);
    int f0;
    f0 = frames;
    for (int t = 0; t < 60000 && frames - f0 < k; t++) @(posedge clk_sys_in);
    if (frames - f0 < k) begin
      fail("frame wait timed out");
      summarize();
    end
  endtask : wait_frames
  // Counts bit clocks from restart until the first driven slot
  task automatic wait_woke(output int cnt);
    cnt = 0;
    while (woke !== 1'b1 && cnt < 400) begin
      @(posedge sck);
      cnt++;
    end
    if (woke !== 1'b1) begin
      fail("no output after wake");
      summarize();
    end
  endtask : wait_woke

  initial begin
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_in);
      run <= 1'b0;
      rst_b <= 1'b0;
      sel <= rows[i].sel;
      pcm <= 24'sh0;
      repeat (10) @(posedge clk_sys_in);
      rst_b <= 1'b1;
      run <= 1'b1;
      wait_woke(n);
      chk_int(n, WAKE, WAKE + 104);
      @(posedge clk_sys_in);
      pcm <= rows[i].val;
      pcm_valid <= 1'b1;
      @(posedge clk_sys_in);
      pcm_valid <= 1'b0;
      // Filter state is zero, so the first word after the step is the step itself
      for (int f = 0; f < 3 && word !== rows[i].val; f++) wait_frames(1);
      chk_word(word, rows[i].val);
      chk_int(bad, 0, 0);
    end
    wait_frames(1);
    n = n_strobe;
    wait_frames(4);
    chk_int(n_strobe - n, 4, 4);
    chk_pwr(pwr, MICSL_HIPERF);
    chk_bit(rps, 1'b0);
    @(posedge clk_sys_in) run <= 1'b0;
    repeat (2500) @(posedge clk_sys_in);
    chk_bit(sd_oe, 1'b0);
    chk_bit(pwr === MICSL_SLEEP || pwr === MICSL_STANDBY, 1'b1);
    @(posedge clk_sys_in) run <= 1'b1;
    wait_woke(n);
    chk_int(n, WAKE, WAKE + 104);
    // 1250 ns bit clock gives a 12.5 kHz frame rate
    @(posedge clk_sys_in) half_ns <= 16'h0271;
    wait_frames(4);
    chk_pwr(pwr, MICSL_LOWPWR);
    chk_bit(rps, 1'b1);
    @(posedge clk_sys_in) half_ns <= 16'h0020;
    wait_frames(4);
    chk_pwr(pwr, MICSL_HIPERF);
    chk_int(bad, 0, 0);
    summarize();
  end
endmodule : micsl_top_test
`default_nettype wire
